// File: design/lpss_pkg.sv
// constants, types and helpers for the load power switch selector
// What this block does
// - host enable high: ignore battery level, follow host control input only; while ctrl_en is set the code follows ctrl_ctl instead
// - host enable low: follow battery level, ignore host control input; while ctrl_en is set the code follows ctrl_ctl instead
// - unconnected host enable reads low, so battery level selects by default
// - host control 1 requests load on, 0 off; effective only when enabled
// - battery level becomes 1 once voltage rises above upper threshold
// - level drops to 0 only below lower threshold; otherwise holds value
// - load on iff (enable low and level 1) or (enable high and control 1); while ctrl_en is set the code uses ctrl_ctl instead
// - resolved decision is registered for one clock, then drives the load switch input
package lpss_pkg;
    localparam int unsigned LPSS_ADDR_W = 8;
    localparam int unsigned LPSS_DATA_W = 32;
    localparam int unsigned LPSS_CNT_W = 16;

    localparam logic [LPSS_ADDR_W-1:0] LPSS_STATUS_OFS = 8'h00;
    localparam logic [LPSS_ADDR_W-1:0] LPSS_CTRL_OFS = 8'h04;
    localparam logic [LPSS_ADDR_W-1:0] LPSS_COUNT_OFS = 8'h08;

    localparam int unsigned LPSS_ST_LEVEL_BIT = 0;
    localparam int unsigned LPSS_ST_EN_BIT = 1;
    localparam int unsigned LPSS_ST_CTL_BIT = 2;
    localparam int unsigned LPSS_ST_LOAD_BIT = 3;
    localparam int unsigned LPSS_CTRL_EN_BIT = 0;
    localparam int unsigned LPSS_CTRL_CTL_BIT = 1;

    localparam logic LPSS_CTRL_EN_RST = 1'b0;
    localparam logic LPSS_CTRL_CTL_RST = 1'b0;
    localparam logic LPSS_LOAD_RST = 1'b0;
    localparam logic [LPSS_CNT_W-1:0] LPSS_CNT_RST = 16'h0000;
    localparam logic [LPSS_CNT_W-1:0] LPSS_CNT_STEP = 16'h0001;
    localparam logic [LPSS_DATA_W-1:0] LPSS_RD_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        LPSS_LVL_LOW = 2'b01,
        LPSS_LVL_HIGH = 2'b10
    } lpss_lvl_e;

    // selector truth table
    function automatic logic lpss_select(input logic en, input logic ctl,
                                         input logic lvl);
        lpss_select = en ? ctl : lvl;
    endfunction
endpackage

// File: design/lpss_reg_if.sv
// register access carrier between the apb slave and the register file
`timescale 1ns/10ps
interface lpss_reg_if;
    import lpss_pkg::*;
    logic wr_stb;
    logic [LPSS_ADDR_W-1:0] addr;
    logic [LPSS_DATA_W-1:0] wdata;
    logic [LPSS_DATA_W-1:0] rdata;
    logic err;
    modport slave (output wr_stb, output addr, output wdata,
                   input rdata, input err);
    modport regs (input wr_stb, input addr, input wdata,
                  output rdata, output err);
endinterface

// File: design/lpss_apb.sv
// apb slave front end, zero wait states
`timescale 1ns/10ps
module lpss_apb
    import lpss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [LPSS_ADDR_W-1:0] paddr,
    input wire logic [LPSS_DATA_W-1:0] pwdata,
    output logic [LPSS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    lpss_reg_if.slave rif
);
    typedef struct packed {
        logic [LPSS_DATA_W-1:0] rdata;
    } lpss_apb_s;

    lpss_apb_s st_q;
    lpss_apb_s st_d;

    assign rif.addr = paddr;
    assign rif.wdata = pwdata;
    assign rif.wr_stb = psel & penable & pwrite & ~rif.err;
    assign pready = 1'b1;
    assign pslverr = psel & penable & rif.err;
    assign prdata = st_q.rdata;

    // read data captured in the setup cycle, presented in the access cycle
    always_comb begin
        st_d = st_q;
        if (psel && !penable && !pwrite) begin
            st_d.rdata = rif.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{rdata: LPSS_RD_ZERO};
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// File: design/lpss_hyst.sv
// battery level hysteresis holder driven by two threshold flags
`timescale 1ns/10ps
module lpss_hyst
    import lpss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic above_hi,
    input wire logic below_lo,
    output logic level
);
    typedef struct packed {
        lpss_lvl_e lvl;
    } lpss_hyst_s;

    lpss_hyst_s st_q;
    lpss_hyst_s st_d;

    always_comb begin
        st_d = st_q;
        case (st_q.lvl)
            LPSS_LVL_LOW: begin
                if (above_hi && !below_lo) begin
                    st_d.lvl = LPSS_LVL_HIGH;
                end
            end
            LPSS_LVL_HIGH: begin
                if (below_lo && !above_hi) begin
                    st_d.lvl = LPSS_LVL_LOW;
                end
            end
            default: begin
                st_d.lvl = LPSS_LVL_LOW;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{lvl: LPSS_LVL_LOW};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = (st_q.lvl == LPSS_LVL_HIGH);
endmodule

// File: design/lpss_top.sv
// load power switch selector top: pins, registers and output drive
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module lpss_top
    import lpss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [LPSS_ADDR_W-1:0] paddr,
    input wire logic [LPSS_DATA_W-1:0] pwdata,
    output logic [LPSS_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_enable,
    input wire logic host_enable_driven,
    input wire logic host_control,
    input wire logic host_control_driven,
    input wire logic bat_above_hi,
    input wire logic bat_below_lo,
    output logic load_switch_on,
    output logic battery_level_out
);
    typedef struct packed {
        logic ctrl_en;
        logic ctrl_ctl;
        logic load_on;
        logic [LPSS_CNT_W-1:0] count;
    } lpss_top_s;

    lpss_top_s st_q;
    lpss_top_s st_d;
    logic battery_level_in;
    logic pin_en;
    logic pin_ctl;
    logic en_eff;
    logic ctl_eff;
    logic sel_on;

    lpss_reg_if rif ();

    lpss_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif.slave)
    );

    lpss_hyst u_hyst (
        .pclk(pclk),
        .presetn(presetn),
        .above_hi(bat_above_hi),
        .below_lo(bat_below_lo),
        .level(battery_level_in)
    );

    // undriven pins read low, like a weak pull-down
    assign pin_en = host_enable & host_enable_driven;
    assign pin_ctl = host_control & host_control_driven;

    // software select acts as a second host enable source
    assign en_eff = pin_en | st_q.ctrl_en;
    assign ctl_eff = st_q.ctrl_en ? st_q.ctrl_ctl : pin_ctl;
    assign sel_on = lpss_select(en_eff, ctl_eff, battery_level_in);

    // register read mux and unmapped detection
    always_comb begin
        rif.rdata = LPSS_RD_ZERO;
        rif.err = 1'b0;
        if (rif.addr == LPSS_STATUS_OFS) begin
            rif.rdata[LPSS_ST_LEVEL_BIT] = battery_level_in;
            rif.rdata[LPSS_ST_EN_BIT] = en_eff;
            rif.rdata[LPSS_ST_CTL_BIT] = ctl_eff;
            rif.rdata[LPSS_ST_LOAD_BIT] = st_q.load_on;
        end else if (rif.addr == LPSS_CTRL_OFS) begin
            rif.rdata[LPSS_CTRL_EN_BIT] = st_q.ctrl_en;
            rif.rdata[LPSS_CTRL_CTL_BIT] = st_q.ctrl_ctl;
        end else if (rif.addr == LPSS_COUNT_OFS) begin
            rif.rdata[LPSS_CNT_W-1:0] = st_q.count;
        end else begin
            rif.err = 1'b1;
        end
    end

    always_comb begin
        st_d = st_q;
        if (rif.wr_stb && rif.addr == LPSS_CTRL_OFS) begin
            st_d.ctrl_en = rif.wdata[LPSS_CTRL_EN_BIT];
            st_d.ctrl_ctl = rif.wdata[LPSS_CTRL_CTL_BIT];
        end
        st_d.load_on = sel_on;
        // count of load turn-on events, cleared by a write to it unless a turn-on in the same cycle increments it instead
        if (sel_on && !st_q.load_on) begin
            st_d.count = st_q.count + LPSS_CNT_STEP;
        end else if (rif.wr_stb && rif.addr == LPSS_COUNT_OFS) begin
            st_d.count = LPSS_CNT_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{ctrl_en: LPSS_CTRL_EN_RST, ctrl_ctl: LPSS_CTRL_CTL_RST,
                      load_on: LPSS_LOAD_RST, count: LPSS_CNT_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign load_switch_on = st_q.load_on;
    assign battery_level_out = battery_level_in;

    // host selection follows control only
    a_host_sel: assert property (@(posedge pclk) disable iff (!presetn)
        en_eff |=> (load_switch_on == $past(ctl_eff)))
        else $error("load does not follow host control while enabled");

    // battery selection ignores control
    a_bat_sel: assert property (@(posedge pclk) disable iff (!presetn)
        !en_eff |=> (load_switch_on == $past(battery_level_in)))
        else $error("load does not follow battery level while disabled");

    // floating enable with no software select gives battery selection
    a_pull_down: assert property (@(posedge pclk) disable iff (!presetn)
        (!host_enable_driven && !st_q.ctrl_en && battery_level_in)
        |=> load_switch_on)
        else $error("floating enable did not default to battery level");

    // host request on
    a_ctl_request: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_en && host_control && host_control_driven && !st_q.ctrl_en)
        |=> load_switch_on)
        else $error("host on request ignored");

    sequence s_low_then_above;
        !battery_level_in ##0 (bat_above_hi && !bat_below_lo);
    endsequence

    // rise above the upper threshold
    a_lvl_rise: assert property (@(posedge pclk) disable iff (!presetn)
        s_low_then_above |=> battery_level_in)
        else $error("battery level did not rise above upper threshold");

    sequence s_high_then_below;
        battery_level_in ##0 (bat_below_lo && !bat_above_hi);
    endsequence

    // fall below the lower threshold
    a_lvl_fall: assert property (@(posedge pclk) disable iff (!presetn)
        s_high_then_below |=> !battery_level_in)
        else $error("battery level did not fall below lower threshold");

    // hold between thresholds
    a_lvl_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!bat_above_hi && !bat_below_lo) [*2] |-> $stable(battery_level_in))
        else $error("battery level moved between thresholds");

    // full truth table
    a_truth_table: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 load_switch_on == lpss_select($past(en_eff), $past(ctl_eff),
                                          $past(battery_level_in)))
        else $error("load output disagrees with selection table");

    // output changes only when the decision changes
    a_drive_out: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(load_switch_on) |-> $past(sel_on) == load_switch_on)
        else $error("load switch drive changed without a decision");

    // level rises only from the upper threshold flag
    a_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(battery_level_in) |-> $past(bat_above_hi))
        else $error("battery level rose without upper flag");

    // each turn-on counted
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(load_switch_on) |-> st_q.count == $past(st_q.count)
            + LPSS_CNT_STEP)
        else $error("turn-on count missed an event");
endmodule

// File: sim/lpss_host_model.sv
// host gpio lines and battery comparator flags facing the selector
`timescale 1ns/10ps
module lpss_host_model #(
    parameter int HI_MV = 3700,
    parameter int LO_MV = 3300
) (
    input wire logic en_req,
    input wire logic en_drive,
    input wire logic ctl_req,
    input wire logic ctl_drive,
    input wire logic signed [31:0] bat_mv,
    output logic host_enable,
    output logic host_enable_driven,
    output logic host_control,
    output logic host_control_driven,
    output logic bat_above_hi,
    output logic bat_below_lo
);
    // a floating line sits at the pull-down level
    assign host_enable = en_drive & en_req;
    assign host_control = ctl_drive & ctl_req;
    assign host_enable_driven = en_drive;
    assign host_control_driven = ctl_drive;
    assign bat_above_hi = bat_mv > HI_MV;
    assign bat_below_lo = bat_mv < LO_MV;
endmodule

// File: sim/load_power_switch_select_test.sv
// self-checking bench for the load power switch selector
`timescale 1ns/10ps
module load_power_switch_select_test;
    import lpss_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, load_switch_on, battery_level_out;
    logic en_req = 1'b0;
    logic en_drive = 1'b1;
    logic ctl_req = 1'b0;
    logic ctl_drive = 1'b1;
    int bat_mv = 3200;
    logic hen, hend, hctl, hctld, above, below;
    int failures = 0;
    int samples_checked = 0;

    always #50 pclk = ~pclk;

    lpss_host_model u_lpss_host_model (.en_req(en_req), .en_drive(en_drive),
        .ctl_req(ctl_req), .ctl_drive(ctl_drive), .bat_mv(bat_mv),
        .host_enable(hen), .host_enable_driven(hend), .host_control(hctl),
        .host_control_driven(hctld), .bat_above_hi(above),
        .bat_below_lo(below));

    lpss_top u_lpss_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_enable(hen), .host_enable_driven(hend), .host_control(hctl),
        .host_control_driven(hctld), .bat_above_hi(above),
        .bat_below_lo(below), .load_switch_on(load_switch_on),
        .battery_level_out(battery_level_out));

    task automatic results();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic drive(input logic en, input logic ctl, input int mv);
        @(posedge pclk);
        en_req <= en;
        ctl_req <= ctl;
        bat_mv <= mv;
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic e;
        chk_bit("load", 1'b0, load_switch_on);
        chk_bit("level", 1'b0, battery_level_out);
        apb(1'b0, LPSS_CTRL_OFS, 32'h00000000, d, e);
        chk_word("ctrl", 32'h00000000, d);
        apb(1'b0, LPSS_STATUS_OFS, 32'h00000000, d, e);
        chk_word("status", 32'h00000000, d);
    endtask

    task automatic t_hyst();
        int mv[5] = '{3800, 3500, 3200, 3500, 3701};
        logic lv[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            drive(1'b0, 1'b1, mv[i]);
            chk_bit("level", lv[i], battery_level_out);
            chk_bit("load", lv[i], load_switch_on);
        end
    endtask

    task automatic t_table();
        // expected load per {level, enable, control}, index 7 down to 0
        logic [7:0] tt = 8'hB8;
        logic l, e, c;
        for (int i = 0; i < 8; i++) begin
            l = i[2];
            e = i[1];
            c = i[0];
            drive(e, c, l ? 3800 : 3200);
            chk_bit("load", tt[i], load_switch_on);
        end
    endtask

    task automatic t_float();
        @(posedge pclk);
        en_drive <= 1'b0;
        drive(1'b1, 1'b0, 3200);
        chk_bit("load", 1'b0, load_switch_on);
        drive(1'b1, 1'b0, 3800);
        chk_bit("load", 1'b1, load_switch_on);
        @(posedge pclk);
        en_drive <= 1'b1;
        ctl_drive <= 1'b0;
        drive(1'b1, 1'b1, 3800);
        chk_bit("load", 1'b0, load_switch_on);
        @(posedge pclk);
        ctl_drive <= 1'b1;
    endtask

    task automatic t_apb();
        logic [31:0] d;
        logic e;
        drive(1'b0, 1'b0, 3200);
        apb(1'b1, LPSS_CTRL_OFS, 32'h00000003, d, e);
        repeat (3) @(posedge pclk);
        #1;
        chk_bit("load", 1'b1, load_switch_on);
        apb(1'b0, LPSS_STATUS_OFS, 32'h00000000, d, e);
        chk_word("status", 32'h0000000E, d);
        chk_bit("pslverr", 1'b0, e);
        apb(1'b0, 8'h0C, 32'h00000000, d, e);
        chk_word("unmapped", 32'h00000000, d);
        chk_bit("pslverr", 1'b1, e);
        drive(1'b0, 1'b0, 3800);
        apb(1'b1, LPSS_CTRL_OFS, 32'h00000001, d, e);
        repeat (3) @(posedge pclk);
        #1;
        chk_bit("load", 1'b0, load_switch_on);
        apb(1'b1, LPSS_COUNT_OFS, 32'h00000000, d, e);
        apb(1'b0, LPSS_COUNT_OFS, 32'h00000000, d, e);
        chk_word("count", 32'h00000000, d);
        apb(1'b1, LPSS_CTRL_OFS, 32'h00000000, d, e);
        repeat (3) @(posedge pclk);
        #1;
        chk_bit("load", 1'b1, load_switch_on);
        apb(1'b0, LPSS_COUNT_OFS, 32'h00000000, d, e);
        chk_word("count", 32'h00000001, d);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_reset();
        t_hyst();
        t_table();
        t_float();
        t_apb();
        results();
    end

    initial begin
        #500000;
        failures++;
        results();
    end
endmodule
